// *** core/alarm_qual.sv ***
`include "st_defines.svh"

module alarm_qual
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic tick_i,
    input wire logic cond_i,
    input wire logic [13:0] limit_ms_i,
    output logic qual_o
);
    logic [13:0] count_q;

    // alarm only after the condition has held for the full limit
    always_ff @(posedge clock_i)
    begin
        if (reset_i || !cond_i)
        begin
            count_q <= 14'h0000;
            qual_o <= 1'b0;
        end
        else if (limit_ms_i == 14'h0000)
        begin
            qual_o <= 1'b1;
        end
        else if (tick_i && !qual_o)
        begin
            if (count_q + 14'h0001 >= limit_ms_i)
            begin
                qual_o <= 1'b1;
            end
            count_q <= count_q + 14'h0001;
        end
    end
endmodule : alarm_qual

// *** core/self_test_monitor.sv ***
`include "st_defines.svh"

module self_test_monitor
#(
    parameter int unsigned TICK_CYC = `ST_TICK_CYCLES
)
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic test_pulse_in_i,
    input wire logic deglitch_select_bit0_i,
    input wire logic deglitch_select_bit1_i,
    input wire logic deglitch_select_bit2_i,
    input wire logic alarm_sharing_select_i,
    input wire logic [2:0] path_cond_i,
    input wire logic [2:0] path_check_ok_i,
    input wire logic [2:0] alarm_chain_in_i,
    output logic [2:0] alarm_voltage_out_o,
    output logic [2:0] alarm_chain_current_out_o
);
    localparam int START_CYC = `ST_START_CYC;
    localparam int HOLD_CYC = `ST_HOLD_CYC;

    st_pkg::st_state_e state_q;
    logic [14:0] div_q;
    logic tick_q;
    logic pulse_q;
    logic rise;
    logic fall;
    logic [2:0] dgt_code;
    logic [13:0] dgt_ms;
    logic slow;
    logic [9:0] win_ms;
    logic [9:0] dur_ms;
    logic [2:0] qual;
    logic [6:0] since_q [3];
    logic [2:0] recent;
    logic [9:0] elapsed_q;
    logic [11:0] cyc_q;
    logic [2:0] fail_q;
    logic [2:0] own_pass;
    logic [2:0] live;
    logic [2:0] out_d;

    ////////////////////////////////////////////////////////////////////////
    // timebase and edges
    always_ff @(posedge clock_i)
    begin
        if (reset_i || div_q == 15'(TICK_CYC - 1))
        begin
            div_q <= 15'h0000;
        end
        else
        begin
            div_q <= div_q + 15'h0001;
        end
        tick_q <= !reset_i && div_q == 15'(TICK_CYC - 1);
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            pulse_q <= 1'b0;
        end
        else
        begin
            pulse_q <= test_pulse_in_i;
        end
    end

    assign rise = test_pulse_in_i && !pulse_q;
    assign fall = !test_pulse_in_i && pulse_q;

    ////////////////////////////////////////////////////////////////////////
    // deglitch selection and live alarms
    assign dgt_code = {deglitch_select_bit0_i, deglitch_select_bit1_i,
                       deglitch_select_bit2_i};

    always_comb
    begin
        case (dgt_code)
            3'h0: dgt_ms = `ST_DGT_0_MS;
            3'h1: dgt_ms = `ST_DGT_1_MS;
            3'h2: dgt_ms = `ST_DGT_2_MS;
            3'h3: dgt_ms = `ST_DGT_3_MS;
            3'h4: dgt_ms = `ST_DGT_4_MS;
            3'h5: dgt_ms = `ST_DGT_5_MS;
            3'h6: dgt_ms = `ST_DGT_6_MS;
            // reserved code: fall back to the shortest nonzero time
            default: dgt_ms = `ST_DGT_1_MS;
        endcase
    end

    assign slow = dgt_code != 3'h0;
    assign win_ms = slow ? `ST_WIN_SLOW_MS : `ST_WIN_FAST_MS;
    assign dur_ms = slow ? `ST_DUR_SLOW_MS : `ST_DUR_FAST_MS;

    genvar p;
    generate
        for (p = 0; p < 3; p++)
        begin : g_path
            alarm_qual u_qual
            (
                .clock_i(clock_i),
                .reset_i(reset_i),
                .tick_i(tick_q),
                .cond_i(path_cond_i[p]),
                .limit_ms_i(dgt_ms),
                .qual_o(qual[p])
            );

            // ms since the raw condition was last seen, saturating
            always_ff @(posedge clock_i)
            begin
                if (reset_i)
                begin
                    since_q[p] <= `ST_SINCE_MAX;
                end
                else if (path_cond_i[p])
                begin
                    since_q[p] <= 7'h00;
                end
                else if (tick_q && since_q[p] != `ST_SINCE_MAX)
                begin
                    since_q[p] <= since_q[p] + 7'h01;
                end
            end

            assign recent[p] = {3'h0, since_q[p]} < win_ms;
        end
    endgenerate

    // shared mode folds every path and the chain into one alarm
    assign live = alarm_sharing_select_i ? (qual | alarm_chain_in_i)
                : {3{|(qual | alarm_chain_in_i)}};

    ////////////////////////////////////////////////////////////////////////
    // self-test sequence
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            state_q <= st_pkg::ST_IDLE;
        end
        else
        begin
            case (state_q)
                st_pkg::ST_IDLE:
                    if (rise)
                        state_q <= st_pkg::ST_START;
                st_pkg::ST_START:
                    if (fall)
                        state_q <= st_pkg::ST_HOLD;
                    else if (cyc_q == 12'(START_CYC - 1))
                        state_q <= st_pkg::ST_RUN;
                st_pkg::ST_RUN:
                    if (fall)
                        state_q <= st_pkg::ST_HOLD;
                    else if (elapsed_q >= dur_ms)
                        state_q <= st_pkg::ST_DONE;
                st_pkg::ST_DONE:
                    if (fall)
                        state_q <= st_pkg::ST_HOLD;
                st_pkg::ST_HOLD:
                    if (rise)
                        state_q <= st_pkg::ST_START;
                    else if (cyc_q == 12'(HOLD_CYC - 1))
                        state_q <= st_pkg::ST_IDLE;
                default:
                    state_q <= st_pkg::ST_IDLE;
            endcase
        end
    end

    // cycle count in short states, ms count since the rising edge
    always_ff @(posedge clock_i)
    begin
        if (reset_i || rise || fall)
        begin
            cyc_q <= 12'h000;
        end
        else if (state_q == st_pkg::ST_START || state_q == st_pkg::ST_HOLD)
        begin
            cyc_q <= cyc_q + 12'h001;
        end
        if (reset_i || rise)
        begin
            elapsed_q <= 10'h000;
        end
        else if (tick_q && elapsed_q != 10'h3FF)
        begin
            elapsed_q <= elapsed_q + 10'h001;
        end
    end

    // an alarm close to the rising edge spoils the result of its path
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            fail_q <= 3'h0;
        end
        else if (rise)
        begin
            fail_q <= recent | path_cond_i;
        end
        else if ((state_q == st_pkg::ST_START || state_q == st_pkg::ST_RUN)
                 && elapsed_q < win_ms)
        begin
            fail_q <= fail_q | path_cond_i;
        end
    end

    // chain pass needs own pass and a pass from above
    assign own_pass = ~fail_q & path_check_ok_i & ~alarm_chain_in_i;

    always_comb
    begin
        case (state_q)
            st_pkg::ST_START: out_d = live;
            st_pkg::ST_RUN: out_d = 3'h7;
            st_pkg::ST_DONE,
            st_pkg::ST_HOLD:
                // low is pass, high is fail; shared mode needs all paths
                out_d = alarm_sharing_select_i ? ~own_pass
                      : {3{~&own_pass}};
            default: out_d = live;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            alarm_voltage_out_o <= 3'h0;
            alarm_chain_current_out_o <= 3'h0;
        end
        else
        begin
            alarm_voltage_out_o <= out_d;
            alarm_chain_current_out_o <= out_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_enter_start;
        state_q == st_pkg::ST_IDLE && rise;
    endsequence

    a_run_forces_high: assert property (@(posedge clock_i) disable iff
        (reset_i) state_q == st_pkg::ST_RUN |=> alarm_voltage_out_o == 3'h7)
        else $error("outputs not high during self-test");

    a_start_shows_live: assert property (@(posedge clock_i) disable iff
        (reset_i) state_q == st_pkg::ST_START |=>
        alarm_voltage_out_o == $past(live))
        else $error("live alarm not shown at test start");

    a_start_bounded: assert property (@(posedge clock_i) disable iff
        (reset_i) s_enter_start ##1 test_pulse_in_i [*2] |->
        ##[0:START_CYC] state_q == st_pkg::ST_RUN || !test_pulse_in_i)
        else $error("test start delay too long");

    // every path is watched, so the bench may raise any of them
    a_window_fail: assert property (@(posedge clock_i) disable iff
        (reset_i) (state_q == st_pkg::ST_RUN && elapsed_q < win_ms &&
        |path_cond_i) |=>
        (fail_q & $past(path_cond_i)) == $past(path_cond_i))
        else $error("alarm near edge did not fail the test");

    a_fail_reads_high: assert property (@(posedge clock_i) disable iff
        (reset_i) (state_q == st_pkg::ST_DONE && fail_q[1] &&
        alarm_sharing_select_i) |=> alarm_voltage_out_o[1])
        else $error("failed path reads low");

    a_chain_gate: assert property (@(posedge clock_i) disable iff
        (reset_i) (state_q == st_pkg::ST_DONE && |alarm_chain_in_i) |=>
        (alarm_chain_current_out_o & $past(alarm_chain_in_i)) ==
        $past(alarm_chain_in_i))
        else $error("pass forwarded without pass from above");

    a_hold_bounded: assert property (@(posedge clock_i) disable iff
        (reset_i) state_q == st_pkg::ST_HOLD |-> cyc_q < 12'(HOLD_CYC))
        else $error("result held too long");

    a_idle_live: assert property (@(posedge clock_i) disable iff
        (reset_i) state_q == st_pkg::ST_IDLE && $past(state_q) ==
        st_pkg::ST_IDLE |=> alarm_voltage_out_o == $past(live))
        else $error("live alarm not restored");

    a_shared_equal: assert property (@(posedge clock_i) disable iff
        (reset_i) !alarm_sharing_select_i |=>
        alarm_voltage_out_o == {3{alarm_voltage_out_o[0]}} ||
        $past(state_q) == st_pkg::ST_START)
        else $error("shared outputs differ");

    a_run_length: assert property (@(posedge clock_i) disable iff
        (reset_i) state_q == st_pkg::ST_RUN |-> elapsed_q <= dur_ms)
        else $error("self-test overran its duration");
endmodule : self_test_monitor

// *** core/st_defines.svh ***
`ifndef ST_DEFINES_SVH
`define ST_DEFINES_SVH

// clock and timebase
`define ST_CLK_HZ 25000000
`define ST_CLK_MHZ 25
`define ST_TICK_CYCLES (`ST_CLK_HZ / 1000)
// windows around the test pulse rising edge, in ms
`define ST_WIN_FAST_MS 10'd20
`define ST_WIN_SLOW_MS 10'd100
// self-test duration, in ms
`define ST_DUR_FAST_MS 10'd25
`define ST_DUR_SLOW_MS 10'd1000
// deglitch times, in ms
`define ST_DGT_0_MS 14'd0
`define ST_DGT_1_MS 14'd80
`define ST_DGT_2_MS 14'd625
`define ST_DGT_3_MS 14'd1250
`define ST_DGT_4_MS 14'd2500
`define ST_DGT_5_MS 14'd5000
`define ST_DGT_6_MS 14'd10000
// test start delay: least time, rounded up
`define ST_START_NS 2000
`define ST_START_CYC ((`ST_START_NS * `ST_CLK_MHZ + 999) / 1000)
// result hold and recovery: longest time, rounded down
`define ST_HOLD_US 100
`define ST_HOLD_CYC (`ST_HOLD_US * `ST_CLK_MHZ)
`define ST_REC_US 100
`define ST_REC_CYC (`ST_REC_US * `ST_CLK_MHZ)
`define ST_SINCE_MAX 7'h7F

`endif

// *** core/st_pkg.sv ***
package st_pkg;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_START = 5'h02,
        ST_RUN   = 5'h04,
        ST_DONE  = 5'h08,
        ST_HOLD  = 5'h10
    } st_state_e;
endpackage : st_pkg

// *** tb/host_model.sv ***
module host_model
(
    input wire logic clock_i,
    input wire logic go_i,
    input wire logic [15:0] high_cyc_i,
    input wire logic [2:0] alarm_i,
    output logic test_pulse_o,
    output logic busy_o,
    output logic [2:0] mid_o,
    output logic [2:0] start_o,
    output logic [2:0] end_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] cnt_q;

    initial
    begin
        test_pulse_o = 1'b0;
        busy_o = 1'b0;
        cnt_q = 16'h0000;
        mid_o = 3'h0;
        start_o = 3'h0;
        end_o = 3'h0;
    end

    // falling-edge drive keeps the pulse settled at the sampling edge
    always @(negedge clock_i)
    begin
        if (!busy_o && go_i)
        begin
            busy_o <= 1'b1;
            cnt_q <= 16'h0000;
            test_pulse_o <= 1'b1;
        end
        else if (busy_o)
        begin
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == 16'h0014)
                mid_o <= alarm_i;
            if (cnt_q == 16'h003C)
                start_o <= alarm_i;
            if (cnt_q == high_cyc_i - 16'h0001)
                end_o <= alarm_i;
            // caller sets high_cyc_i past the longest
            if (cnt_q == high_cyc_i)
            begin
                test_pulse_o <= 1'b0;
                busy_o <= 1'b0;
            end
        end
    end
endmodule : host_model

// *** tb/safety_monitor_self_test_timing_tb_top.sv ***
module safety_monitor_self_test_timing_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // one ms tick every 10 cycles keeps the 1 s test short
    localparam int TICK = 10;
    localparam int CEIL = 90000;
    logic clock_i, reset_i, sel, go, pulse, busy;
    logic [2:0] dgt, cond, ok, chain, av, ac, mid, st, en;
    logic [15:0] hi;
    int mismatches, checked, cycles;

    self_test_monitor #(.TICK_CYC(TICK)) dut
    (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .test_pulse_in_i(pulse),
        .deglitch_select_bit0_i(dgt[2]),
        .deglitch_select_bit1_i(dgt[1]),
        .deglitch_select_bit2_i(dgt[0]),
        .alarm_sharing_select_i(sel),
        .path_cond_i(cond),
        .path_check_ok_i(ok),
        .alarm_chain_in_i(chain),
        .alarm_voltage_out_o(av),
        .alarm_chain_current_out_o(ac)
    );

    host_model host
    (
        .clock_i(clock_i),
        .go_i(go),
        .high_cyc_i(hi),
        .alarm_i(av),
        .test_pulse_o(pulse),
        .busy_o(busy),
        .mid_o(mid),
        .start_o(st),
        .end_o(en)
    );

    initial clock_i = 1'b0;
    always #20 clock_i = ~clock_i;

    always @(posedge clock_i)
    begin
        cycles = cycles + 1;
        if (cycles >= CEIL)
        begin
            mismatches = mismatches + 1;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        checked = checked + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_out(input logic [2:0] exp);
        chk(av, exp);
        chk(ac, exp);
    endtask : chk_out

    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 20000)
        begin
            @(negedge clock_i);
            n = n + 1;
        end
        if (n >= 20000)
        begin
            mismatches = mismatches + 1;
            end_sim();
        end
    endtask : wait_busy

    // selects are static in use, so every change goes through a reset
    task automatic cfg(input logic [2:0] d, input logic s,
                       input logic [2:0] k, input logic [2:0] c);
        dgt = d;
        sel = s;
        ok = k;
        chain = c;
        cond = 3'h0;
        reset_i = 1'b1;
        repeat (6) @(negedge clock_i);
        reset_i = 1'b0;
        repeat (2) @(negedge clock_i);
    endtask : cfg

    task automatic pre_alarm(input logic [2:0] b, input int ms);
        cond = b;
        repeat (20) @(negedge clock_i);
        cond = 3'h0;
        repeat (ms * TICK - 20) @(negedge clock_i);
    endtask : pre_alarm

    task automatic run_test(input int hi_c, input int at,
                            input logic [2:0] pc, input logic [2:0] ch,
                            input logic [2:0] e_mid, input logic [2:0] e_end,
                            input logic [2:0] e_live);
        hi = hi_c[15:0];
        go <= 1'b1;
        wait_busy(1'b1);
        go <= 1'b0;
        if (at > 0)
        begin
            repeat (at) @(negedge clock_i);
            cond = cond ^ pc;
            chain = chain ^ ch;
            repeat (10) @(negedge clock_i);
            cond = cond ^ pc;
        end
        wait_busy(1'b0);
        chk(mid, e_mid);
        chk(st, 3'h7);
        chk(en, e_end);
        repeat (2300) @(negedge clock_i);
        chk_out(e_end);
        repeat (220) @(negedge clock_i);
        chk_out(e_live);
    endtask : run_test

    task automatic dgt_test(input logic [2:0] d, input int ms);
        cfg(d, 1'b1, 3'h7, 3'h0);
        cond = 3'h1;
        if (ms > 0)
        begin
            repeat ((ms - 10) * TICK) @(negedge clock_i);
            chk_out(3'h0);
        end
        repeat (ms > 0 ? 20 * TICK : 3) @(negedge clock_i);
        chk_out(3'h1);
    endtask : dgt_test

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        mismatches = 0;
        checked = 0;
        cycles = 0;
        go = 1'b0;
        hi = 16'h0190;
        cfg(3'h0, 1'b1, 3'h7, 3'h0);
        run_test(400, 0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0);
        cfg(3'h0, 1'b1, 3'h5, 3'h0);
        run_test(400, 0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h0);
        cfg(3'h0, 1'b0, 3'h5, 3'h0);
        run_test(400, 0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h0);
        cfg(3'h0, 1'b1, 3'h7, 3'h0);
        pre_alarm(3'h4, 15);
        run_test(400, 0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h0);
        run_test(400, 0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0);
        pre_alarm(3'h4, 30);
        run_test(400, 0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0);
        run_test(400, 100, 3'h2, 3'h0, 3'h0, 3'h2, 3'h0);
        cfg(3'h0, 1'b1, 3'h7, 3'h2);
        run_test(400, 0, 3'h0, 3'h0, 3'h2, 3'h2, 3'h2);
        run_test(400, 350, 3'h0, 3'h2, 3'h2, 3'h0, 3'h0);
        cfg(3'h1, 1'b1, 3'h7, 3'h0);
        run_test(10100, 0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0);
        pre_alarm(3'h1, 60);
        run_test(10100, 0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0);
        dgt_test(3'h0, 0);
        dgt_test(3'h1, 80);
        dgt_test(3'h2, 625);
        dgt_test(3'h7, 80);
        end_sim();
    end
endmodule : safety_monitor_self_test_timing_tb_top
